// File: ccs_pkg.sv
/*
  Shared constants of the CPU clock source switcher: bit positions of
  the register images, reset values and cycle counts.
  Assumes nothing of its surroundings.
*/
package ccs_pkg;
  // ==========================================================
  // Register image bit positions
  localparam int CCS_MAIN_OSC_STOP_BIT = 7;
  localparam int CCS_INT_OSC_STOP_BIT = 0;
  localparam int CCS_SOURCE_SELECT_BIT = 0;
  localparam int CCS_SOURCE_STATUS_BIT = 1;

  // ==========================================================
  // Reset values and counts
  localparam logic [2:0] CCS_DIV_RST = 3'h0;
  localparam logic [2:0] CCS_DIV_MAX = 3'h4;
  localparam logic [7:0] CCS_MODE_RD_RST = 8'h00;
  // Internal oscillator cycles before the CPU clock starts
  localparam logic [4:0] CCS_START_INT_CYCLES = 5'h11;
  // Old CPU clocks needed to move onto the high-speed clock
  localparam logic [1:0] CCS_TO_MAIN_CLOCKS = 2'h2;

  // ==========================================================
  // Operating states, one-hot
  typedef enum logic [4:0] {
    CCS_ST_RESET = 5'h01,
    CCS_ST_START = 5'h02,
    CCS_ST_RUN = 5'h04,
    CCS_ST_HALT = 5'h08,
    CCS_ST_STOP = 5'h10
  } ccs_state_t;
endpackage

// File: ccs_edge_sync.sv
/*
  Two-flop synchroniser with a rising edge detector behind it.
  Assumes an asynchronous input that is slow against i_clock.
*/
module ccs_edge_sync (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Asynchronous input
  input wire logic i_async,
  // Synchronised level and its rising edge
  output logic o_level,
  output logic o_rise
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } ccs_sync_t;

  ccs_sync_t s_ff;
  ccs_sync_t nxt_s;

  // ==========================================================
  // Next state: the first flop feeds only the second
  always_comb begin
    nxt_s = s_ff;
    nxt_s.meta = i_async;
    nxt_s.sync = s_ff.meta;
    nxt_s.prev = s_ff.sync;
  end

  // State register
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_level = s_ff.sync;
  assign o_rise = s_ff.sync & ~s_ff.prev;
endmodule

// File: ccs_switcher.sv
/*
  CPU clock source switcher: picks the CPU clock between the high-speed
  and the internal oscillator, gates both oscillators, runs the reset,
  start, HALT and STOP sequence and delays source and divider changes.
  Assumes the oscillators arrive as raw clocks on pins, the register
  images are held by CPU-side logic on i_clock, and standby requests,
  wake and internal reset sources come from logic on i_clock.
*/
// Notes on behaviour
// R1: Software stops internal oscillator only while status reads high-speed.
// R2: Software checks stabilization before selecting high-speed after reset.
// R3: Software stops high-speed oscillator only while status reads internal.
// R4: Software-stoppable option: watchdog halts in HALT and STOP.
// R5: Every reset source forces the reset state.
// R6: Non-stoppable option: watchdog keeps counting through STOP.
// R7: Software clears watchdog from auxiliary timer while in STOP.
// R8: STOP release resumes on the source used at STOP entry.
// R9: HALT release resumes on the source used at HALT entry.
// R10: Internal stop bit honoured only with software-stoppable option.
// R11: Stop bits at bit 7 and bit 0; select at bit 0.
// R12: After select rewrite, old clock continues for a bounded time.
// R13: Status at bit 1 reports the clock source, 1 high-speed.
// R14: Switch costs one internal period plus one, or two clocks.
// R15: Software waits the switch latency before stopping old oscillator.
// R16: Worst-case latency assumes internal oscillator at 120 kHz.
// R17: Three-bit divider change waits on the old divided clock.
// R18: Divider latency 16, 8, 4, 2, 1 clocks by prior setting.
// R19: Software avoids dividers 010, 011, 100 on internal clock.
// R20: Reset selects internal clock; CPU clock after 17 cycles.
// R21: High-speed oscillator keeps running while it clocks the CPU.
// R22: Both stop bits set still leaves one oscillator running.
module ccs_switcher
  import ccs_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Raw oscillator clocks from the pins
  input wire logic i_main_osc_clk,
  input wire logic i_int_osc_clk,
  // Reset sources
  input wire logic i_reset_pin,
  input wire logic i_power_on_clear,
  input wire logic i_low_voltage_detect,
  input wire logic i_clock_monitor,
  input wire logic i_watchdog_overflow,
  // Option and register images
  input wire logic i_int_osc_stoppable,
  input wire logic [7:0] i_main_clock_mode_reg,
  input wire logic [7:0] i_main_osc_control_reg,
  input wire logic [7:0] i_internal_osc_mode_reg,
  input wire logic [2:0] i_cpu_divider_control,
  // Standby control
  input wire logic i_halt_req,
  input wire logic i_stop_req,
  input wire logic i_wake,
  // CPU clock and status
  output logic o_cpu_clk_en,
  output logic [2:0] o_cpu_divider,
  output logic o_clock_source_status,
  output logic [7:0] o_main_clock_mode_reg,
  output logic [4:0] o_state,
  // Oscillator and watchdog enables
  output logic o_main_osc_en,
  output logic o_int_osc_en,
  output logic o_watchdog_run
);
  typedef struct packed {
    ccs_state_t state;
    logic status;
    logic [2:0] div_ff;
    logic [4:0] div_cnt;
    logic cpu_tick;
    logic sw_pend;
    logic [1:0] sw_cnt;
    logic seen_int;
    logic dv_pend;
    logic [4:0] dv_cnt;
    logic [4:0] start_cnt;
    logic main_en;
    logic int_en;
    logic watchdog_run;
    logic [7:0] mode_rd;
  } ccs_core_t;

  ccs_core_t s_ff;
  ccs_core_t nxt_s;

  // ==========================================================
  // Helpers
  // Old divided clocks to wait before a divider change lands
  function automatic logic [4:0] ccs_div_lat(input logic [2:0] d);
    if (d > CCS_DIV_MAX) begin
      ccs_div_lat = 5'h01;
    end else begin
      ccs_div_lat = 5'h10 >> d;
    end
  endfunction

  // Oscillator ticks per CPU tick, less one
  function automatic logic [4:0] ccs_div_top(input logic [2:0] d);
    logic [2:0] dc;
    dc = (d > CCS_DIV_MAX) ? CCS_DIV_MAX : d;
    ccs_div_top = (5'h01 << dc) - 5'h01;
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic main_rise;
  logic int_rise;
  logic rst_pin_lvl;

  ccs_edge_sync u_main_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(i_main_osc_clk),
    .o_level(),
    .o_rise(main_rise)
  );

  ccs_edge_sync u_int_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(i_int_osc_clk),
    .o_level(),
    .o_rise(int_rise)
  );

  ccs_edge_sync u_rst_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(i_reset_pin),
    .o_level(rst_pin_lvl),
    .o_rise()
  );

  // Ticks count only while the oscillator is enabled
  logic main_t;
  logic int_t;
  logic reset_src;
  logic sel;
  logic main_stop_bit;
  logic int_stop_bit;

  assign main_t = main_rise & s_ff.main_en;
  assign int_t = int_rise & s_ff.int_en;
  assign reset_src = rst_pin_lvl | i_power_on_clear |
                     i_low_voltage_detect | i_clock_monitor |
                     i_watchdog_overflow; // R5
  assign sel = i_main_clock_mode_reg[CCS_SOURCE_SELECT_BIT]; // R11
  assign main_stop_bit = i_main_osc_control_reg[CCS_MAIN_OSC_STOP_BIT]; // R11
  assign int_stop_bit = i_internal_osc_mode_reg[CCS_INT_OSC_STOP_BIT]; // R11

  // ==========================================================
  // Next state
  always_comb begin
    logic src_t;
    logic tick_now;
    src_t = 1'b0;
    tick_now = 1'b0;
    nxt_s = s_ff;
    nxt_s.cpu_tick = 1'b0;
    src_t = s_ff.status ? main_t : int_t;
    unique case (s_ff.state)
      CCS_ST_RESET: begin
        nxt_s.state = CCS_ST_START;
        nxt_s.start_cnt = 5'h00;
      end
      CCS_ST_START: begin
        // CPU clock is held off until the internal oscillator settles
        if (int_t) begin
          if (s_ff.start_cnt == CCS_START_INT_CYCLES - 5'h01) begin
            nxt_s.state = CCS_ST_RUN; // R20
          end else begin
            nxt_s.start_cnt = s_ff.start_cnt + 5'h01;
          end
        end
      end
      CCS_ST_RUN: begin
        if (i_stop_req) begin
          nxt_s.state = CCS_ST_STOP;
        end else if (i_halt_req) begin
          nxt_s.state = CCS_ST_HALT;
        end else begin
          // Divide the selected oscillator into CPU ticks
          if (src_t) begin
            if (s_ff.div_cnt >= ccs_div_top(s_ff.div_ff)) begin
              nxt_s.div_cnt = 5'h00;
              tick_now = 1'b1;
            end else begin
              nxt_s.div_cnt = s_ff.div_cnt + 5'h01;
            end
          end
          nxt_s.cpu_tick = tick_now;
          // Source switch, timed in old CPU clocks
          if (sel == s_ff.status) begin
            nxt_s.sw_pend = 1'b0;
          end else if (!s_ff.sw_pend) begin
            nxt_s.sw_pend = 1'b1; // R12
            nxt_s.sw_cnt = 2'h0;
            nxt_s.seen_int = 1'b0;
          end else begin
            if (int_t) begin
              nxt_s.seen_int = 1'b1;
            end
            if (tick_now) begin
              if (!s_ff.status) begin
                if (s_ff.sw_cnt == CCS_TO_MAIN_CLOCKS - 2'h1) begin
                  nxt_s.status = 1'b1; // R14
                  nxt_s.sw_pend = 1'b0;
                  nxt_s.div_cnt = 5'h00;
                end else begin
                  nxt_s.sw_cnt = s_ff.sw_cnt + 2'h1;
                end
              end else if (s_ff.seen_int) begin
                // One internal period seen, then one more old tick
                nxt_s.status = 1'b0; // R14
                nxt_s.sw_pend = 1'b0;
                nxt_s.div_cnt = 5'h00;
              end
            end
          end
          // Divider change, timed in old divided clocks
          if (i_cpu_divider_control == s_ff.div_ff) begin
            nxt_s.dv_pend = 1'b0;
          end else if (!s_ff.dv_pend) begin
            nxt_s.dv_pend = 1'b1; // R17
            nxt_s.dv_cnt = 5'h00;
          end else if (tick_now) begin
            if (s_ff.dv_cnt == ccs_div_lat(s_ff.div_ff) - 5'h01) begin
              nxt_s.div_ff = i_cpu_divider_control; // R18
              nxt_s.dv_pend = 1'b0;
              nxt_s.div_cnt = 5'h00;
            end else begin
              nxt_s.dv_cnt = s_ff.dv_cnt + 5'h01;
            end
          end
        end
      end
      // Source and divider are frozen, so release resumes on them
      CCS_ST_HALT: begin
        if (i_wake) begin
          nxt_s.state = CCS_ST_RUN; // R9
        end
      end
      CCS_ST_STOP: begin
        if (i_wake) begin
          nxt_s.state = CCS_ST_RUN; // R8
        end
      end
      default: begin
        nxt_s.state = CCS_ST_RESET;
      end
    endcase
    // Any reset source restarts from the internal oscillator
    if (reset_src) begin
      nxt_s = '0; // R5
      nxt_s.state = CCS_ST_RESET; // R20
      nxt_s.div_ff = CCS_DIV_RST;
    end
    // Oscillator gating; a stop bit never stops the clocking oscillator
    if (s_ff.state == CCS_ST_RESET || reset_src) begin
      nxt_s.main_en = 1'b0;
      nxt_s.int_en = 1'b0;
    end else begin
      nxt_s.main_en = (s_ff.state != CCS_ST_STOP) &&
                      !(main_stop_bit && !s_ff.status); // R21
      // Stop bit only when stoppable and high-speed clocks the CPU
      nxt_s.int_en = !(i_int_osc_stoppable && int_stop_bit &&
                       s_ff.status); // R10 R22
    end
    // Watchdog runs through standby only when oscillator is fixed
    unique case (s_ff.state)
      CCS_ST_START, CCS_ST_RUN: nxt_s.watchdog_run = !reset_src;
      CCS_ST_HALT, CCS_ST_STOP:
        nxt_s.watchdog_run = !i_int_osc_stoppable && !reset_src; // R4 R6
      default: nxt_s.watchdog_run = 1'b0;
    endcase
    nxt_s.mode_rd = CCS_MODE_RD_RST;
    if (!reset_src) begin
      nxt_s.mode_rd[CCS_SOURCE_SELECT_BIT] = sel;
    end
    nxt_s.mode_rd[CCS_SOURCE_STATUS_BIT] = nxt_s.status; // R13
  end

  // State register
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s_ff <= '0;
      s_ff.state <= CCS_ST_RESET;
      s_ff.div_ff <= CCS_DIV_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================
  // Outputs, all from the state register
  assign o_cpu_clk_en = s_ff.cpu_tick;
  assign o_cpu_divider = s_ff.div_ff;
  assign o_clock_source_status = s_ff.status;
  assign o_main_clock_mode_reg = s_ff.mode_rd;
  assign o_state = s_ff.state;
  assign o_main_osc_en = s_ff.main_en;
  assign o_int_osc_en = s_ff.int_en;
  assign o_watchdog_run = s_ff.watchdog_run;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_reset_src_state: assert property (reset_src |=>
    s_ff.state == CCS_ST_RESET && !s_ff.status) // R5
    else $error("reset source did not force reset state");
  a_start_no_clock: assert property (s_ff.state != CCS_ST_RUN |=>
    !o_cpu_clk_en) // R20
    else $error("CPU clock ran outside run state");
  a_start_count_done: assert property ($rose(s_ff.state == CCS_ST_RUN)
    && $past(s_ff.state) == CCS_ST_START |->
    $past(s_ff.start_cnt) == 5'h10) // R20
    else $error("start wait was not 17 internal cycles");
  a_watchdog_halts: assert property ((s_ff.state == CCS_ST_HALT ||
    s_ff.state == CCS_ST_STOP) && i_int_osc_stoppable |=>
    !o_watchdog_run) // R4
    else $error("watchdog ran in standby with stoppable option");
  a_watchdog_in_stop: assert property (s_ff.state == CCS_ST_STOP &&
    !i_int_osc_stoppable && !reset_src |=> o_watchdog_run) // R6
    else $error("watchdog stopped in STOP with fixed option");
  a_standby_source: assert property ((s_ff.state == CCS_ST_HALT ||
    s_ff.state == CCS_ST_STOP) && !reset_src |=>
    $stable(o_clock_source_status) && $stable(o_cpu_divider)) // R8 R9
    else $error("clock source changed during standby");
  a_int_not_stopped: assert property (!i_int_osc_stoppable &&
    s_ff.state != CCS_ST_RESET && !reset_src |=> o_int_osc_en) // R10
    else $error("internal oscillator stopped while not stoppable");
  a_main_kept: assert property (s_ff.status && !reset_src &&
    s_ff.state == CCS_ST_RUN |=> o_main_osc_en) // R21 R22
    else $error("high-speed oscillator stopped while clocking CPU");
  a_to_main_lat: assert property ($rose(s_ff.status) |->
    $past(s_ff.sw_cnt) == 2'h1 && $past(nxt_s.cpu_tick)) // R12 R14
    else $error("switch to high-speed not after two old clocks");
  a_div_latency: assert property ($changed(s_ff.div_ff) &&
    !$past(reset_src) |-> $past(s_ff.dv_cnt) ==
    ccs_div_lat($past(s_ff.div_ff)) - 5'h01) // R18
    else $error("divider changed after wrong number of clocks");
  a_status_bit: assert property (o_main_clock_mode_reg[1] ==
    o_clock_source_status) // R13
    else $error("status bit disagrees with clock source");

  c_reach_run: cover property (s_ff.state == CCS_ST_RUN && o_cpu_clk_en);
  c_switch_main: cover property ($rose(s_ff.status));
  c_stop_wake: cover property (s_ff.state == CCS_ST_STOP ##1
    s_ff.state == CCS_ST_RUN);
endmodule

// File: ccs_switcher_bench.sv
/*
  Self-checking bench for the CPU clock source switcher: drives reset,
  oscillators, register images and standby requests, and checks state,
  status, divider, enables and switch latencies through a note queue.
  Assumes ccs_pkg and ccs_switcher are compiled before this file.
*/
module ccs_switcher_bench
  import ccs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Stimulus and observed signals
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic main_osc = 1'b0;
  logic int_osc = 1'b0;
  logic [4:0] rsrc = 5'h00;
  logic stoppable = 1'b1;
  logic [7:0] mode_img = 8'h00;
  logic [7:0] osc_img = 8'h00;
  logic [7:0] int_img = 8'h00;
  logic [2:0] div_req = 3'h0;
  logic halt_req = 1'b0;
  logic stop_req = 1'b0;
  logic wake = 1'b0;
  logic cpu_en;
  logic [2:0] cpu_div;
  logic status;
  logic [7:0] mode_rd;
  logic [4:0] state;
  logic main_en;
  logic int_en;
  logic watchdog_run;
  int seed = 32'h795e38dd;
  int fails = 0;
  int n_tests = 0;
  int ticks = 0;
  int base = 0;
  logic [2:0] divs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
  typedef struct {string nm; int sel; logic [7:0] exp; int base;} ccs_note_t;
  ccs_note_t notes[$];

  // Raw oscillators kept well below a quarter of the system clock
  always #5 i_clock = ~i_clock;
  always #40 main_osc = ~main_osc;
  always #200 int_osc = ~int_osc;

  ccs_switcher i_ccs_switcher (
    .i_clock(i_clock), .i_rst(i_rst),
    .i_main_osc_clk(main_osc), .i_int_osc_clk(int_osc),
    .i_reset_pin(rsrc[0]), .i_power_on_clear(rsrc[1]),
    .i_low_voltage_detect(rsrc[2]), .i_clock_monitor(rsrc[3]),
    .i_watchdog_overflow(rsrc[4]), .i_int_osc_stoppable(stoppable),
    .i_main_clock_mode_reg(mode_img), .i_main_osc_control_reg(osc_img),
    .i_internal_osc_mode_reg(int_img), .i_cpu_divider_control(div_req),
    .i_halt_req(halt_req), .i_stop_req(stop_req), .i_wake(wake),
    .o_cpu_clk_en(cpu_en), .o_cpu_divider(cpu_div),
    .o_clock_source_status(status), .o_main_clock_mode_reg(mode_rd),
    .o_state(state), .o_main_osc_en(main_en), .o_int_osc_en(int_en),
    .o_watchdog_run(watchdog_run)
  );

  // ==========================================================
  // Checking
  function automatic logic [7:0] pick(input int sel);
    case (sel)
      0: pick = {3'h0, state};
      1: pick = {7'h0, status};
      2: pick = {5'h0, cpu_div};
      3: pick = {7'h0, main_en};
      4: pick = {7'h0, int_en};
      5: pick = {7'h0, watchdog_run};
      6: pick = mode_rd;
      default: pick = {7'h0, cpu_en};
    endcase
  endfunction

  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // Monitor: counts CPU ticks, then settles every pending note
  always @(negedge i_clock) begin
    ccs_note_t n;
    logic [7:0] seen;
    if (cpu_en === 1'b1) ticks++;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      seen = pick(n.sel);
      if (n.sel == 7) seen = 8'(ticks - n.base);
      if (n.sel == 8) begin
        seen = {7'h0, (ticks > n.base) && (ticks - n.base <= int'(n.exp))};
        n.exp = 8'h01;
      end
      check(n.nm, seen, n.exp);
    end
  end

  // ==========================================================
  // Driver tasks
  task automatic step(input int n = 1);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic note(input string nm, input int sel, input logic [7:0] e);
    notes.push_back('{nm, sel, e, base});
  endtask

  // Bounded wait on an output; running out counts as a mismatch
  task automatic await(input int sel, input logic [7:0] val, input int lim);
    int k;
    k = 0;
    while (pick(sel) !== val && k < lim) begin
      step();
      k++;
    end
    if (k >= lim) begin
      check("await", pick(sel), val);
    end
  endtask

  // Start a count just after a CPU tick, so the write lands between ticks
  task automatic after_tick();
    await(9, 8'h01, 3000);
    step();
    base = ticks;
  endtask

  // Control bits with random filler in the ignored positions
  task automatic regs(input logic sel, input logic ms, input logic is);
    mode_img = {7'($random(seed)), sel};
    osc_img = {ms, 7'($random(seed))};
    int_img = {7'($random(seed)), is};
  endtask

  task automatic final_report();
    if (fails == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog against a hang, far beyond the expected run time
  initial begin
    #400000;
    fails++;
    final_report();
  end

  // ==========================================================
  // Main sequence
  initial begin
    regs(1'b0, 1'b0, 1'b0);
    step(20);
    note("state", 0, 8'h01);
    note("int_en", 4, 8'h00);
    i_rst = 1'b0;
    await(0, 8'h02, 5);
    note("status", 1, 8'h00);
    await(0, 8'h04, 2000);
    // Onto the high-speed clock: two old ticks, then status follows
    after_tick();
    // High-speed oscillator has run since time zero, so it is settled
    regs(1'b1, 1'b0, 1'b0);
    await(1, 8'h01, 500);
    note("to_main_ticks", 7, 8'h02);
    note("mode_rd", 6, 8'h03);
    // Divider walk; latency depends on the setting being left
    for (int i = 0; i < 5; i++) begin
      after_tick();
      div_req = divs[i + 1];
      await(2, {5'h0, divs[i + 1]}, 3000);
      note("div_ticks", 7, 8'(16 >> divs[i]));
    end
    // Internal stop bit only obeyed when the option allows it
    regs(1'b1, 1'b0, 1'b1);
    step(4);
    note("int_en", 4, 8'h00);
    stoppable = 1'b0;
    step(4);
    note("int_en", 4, 8'h01);
    stoppable = 1'b1;
    regs(1'b1, 1'b1, 1'b1);
    step(4);
    note("main_en", 3, 8'h01);
    regs(1'b1, 1'b0, 1'b0);
    // HALT with a stoppable internal oscillator
    halt_req = 1'b1;
    step();
    halt_req = 1'b0;
    await(0, 8'h08, 5);
    step(3);
    note("watchdog_run", 5, 8'h00);
    note("int_en", 4, 8'h01);
    wake = 1'b1;
    step();
    wake = 1'b0;
    await(0, 8'h04, 5);
    note("status", 1, 8'h01);
    // STOP with a non-stoppable internal oscillator
    stoppable = 1'b0;
    stop_req = 1'b1;
    step();
    stop_req = 1'b0;
    await(0, 8'h10, 5);
    step(3);
    note("watchdog_run", 5, 8'h01);
    // Early wake stands in for the periodic watchdog clear
    wake = 1'b1;
    step();
    wake = 1'b0;
    await(0, 8'h04, 5);
    note("status", 1, 8'h01);
    stoppable = 1'b1;
    // Every reset source drops back to the internal clock
    for (int k = 0; k < 5; k++) begin
      rsrc[k] = 1'b1;
      step(4);
      note("state", 0, 8'h01);
      note("status", 1, 8'h00);
      note("main_en", 3, 8'h00);
      rsrc[k] = 1'b0;
      await(0, 8'h04, 2000);
      await(1, 8'h01, 500);
    end
    // Back to the internal clock: oscillator ratio (5) plus one old ticks
    after_tick();
    regs(1'b0, 1'b0, 1'b0);
    await(1, 8'h00, 3000);
    note("to_int_ticks", 8, 8'h06);
    // Stop bits on the internal clock: high-speed oscillator stops, internal keeps running
    regs(1'b0, 1'b1, 1'b0);
    step(4);
    note("main_en", 3, 8'h00);
    regs(1'b0, 1'b1, 1'b1);
    step(4);
    note("int_en", 4, 8'h01);
    regs(1'b0, 1'b0, 1'b0);
    step(3);
    final_report();
  end
endmodule
